// *** scp_consts.svh ***
// scp_consts.svh: named constants of the serial configuration port
// assumes it is included by bare name from the regfile, top, property and bench files
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// address and data widths of the register space
`define SCP_ADDR_W 7
`define SCP_DATA_W 8
`define SCP_NREGS 128

// instruction byte layout
`define SCP_RW_BIT 7

// communication register and its fields
`define SCP_COMM_ADDR 7'h00
`define SCP_COMM_BIDIR_BIT 7
`define SCP_COMM_LSBF_BIT 6
`define SCP_COMM_DEF 8'h00

// frequency update control
`define SCP_FUPD_ADDR 7'h36
`define SCP_FUPD_BIT 0

// bit counter and address step values
`define SCP_BIT_FIRST 3'h0
`define SCP_BIT_LAST 3'h7
`define SCP_BIT_STEP 3'h1
`define SCP_ADDR_STEP 7'h01

`endif

// *** scp_pkg.sv ***
// scp_pkg: types shared by the serial configuration port files
// assumes scp_consts.svh sits in the same folder
package scp_pkg;

  // phase of a communication cycle
  typedef enum logic {
    SCP_INSTR,
    SCP_DATA
  } scp_phase_t;

endpackage

// *** scp_regfile.sv ***
// scp_regfile: configuration register array on the serial clock
// assumes writes arrive on the serial clock edge ending a data byte;
// exports each write as a held word plus a toggle for the core domain
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_regfile
  import scp_pkg::*;
(
  // serial clock domain
  input wire logic sclk_i,
  input wire logic arst_i,
  // write port
  input wire logic we_i,
  input wire logic [`SCP_ADDR_W-1:0] waddr_i,
  input wire logic [`SCP_DATA_W-1:0] wdata_i,
  // read port
  input wire logic [`SCP_ADDR_W-1:0] raddr_i,
  output logic [`SCP_DATA_W-1:0] rdata_o,
  output logic [`SCP_DATA_W-1:0] comm_o,
  // write event toward the core clock
  output logic wr_tog_o,
  output logic [`SCP_ADDR_W-1:0] wr_addr_o,
  output logic [`SCP_DATA_W-1:0] wr_data_o
);

  typedef struct packed {
    logic [`SCP_NREGS-1:0][`SCP_DATA_W-1:0] mem;
    logic tog;
    logic [`SCP_ADDR_W-1:0] waddr;
    logic [`SCP_DATA_W-1:0] wdata;
  } scp_rf_state_t;

  scp_rf_state_t q, d;

  // store the byte and flip the toggle; word stays put until next write
  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[waddr_i] = wdata_i;
      d.tog = ~q.tog;
      d.waddr = waddr_i;
      d.wdata = wdata_i;
    end
  end

  // reset is asynchronous here: the serial clock is stopped during it
  always_ff @(posedge sclk_i or posedge arst_i) begin
    if (arst_i) begin
      q <= '0;
      q.mem[`SCP_COMM_ADDR] <= `SCP_COMM_DEF;
    end else begin
      q <= d;
    end
  end

  // every register reads back through the serial port
  assign rdata_o = q.mem[raddr_i];
  assign comm_o = q.mem[`SCP_COMM_ADDR];
  assign wr_tog_o = q.tog;
  assign wr_addr_o = q.waddr;
  assign wr_data_o = q.wdata;

endmodule // scp_regfile

// *** scp_top.sv ***
// scp_top: serial configuration port, link logic on the serial clock,
// write delivery and held-register staging on the core clock
// assumes the host keeps the serial clock still while chip select is high
// and while rst_i is active; pad logic resolves the pins from the enables
//
// Notes on behaviour
// - each cycle opens with an instruction byte on the first eight rises
// - instruction byte decides read or write and the first register address
// - chip select high then low restarts at the instruction phase
// - all later clock edges carry one or more whole data bytes
// - a written register changes on the last bit of each byte
// - tuning word and phase offsets apply only on frequency update bit
// - data may use one two-way pin or separate input and output pins
// - single or multi-byte transfers, MSB-first or LSB-first as configured
// - every configuration register is readable and writable here
// - instruction bit 7 high means read; low seven bits are the address
// - input sampled on rising edges, output driven on falling edges
// - both data pins float while chip select is high
// - address decrements in MSB-first mode, increments in LSB-first mode
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_top
  import scp_pkg::*;
#(
  parameter logic [`SCP_ADDR_W-1:0] HOLD_BASE = 7'h30,
  parameter int HOLD_CNT = 6
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_o,
  // register writes toward the device core
  output logic reg_wr_o,
  output logic [`SCP_ADDR_W-1:0] reg_addr_o,
  output logic [`SCP_DATA_W-1:0] reg_data_o,
  // staged tuning and phase registers
  output logic freq_update_o,
  output logic [HOLD_CNT*`SCP_DATA_W-1:0] held_active_o
);

  // one struct per clock edge; a single struct cannot span two clocks
  typedef struct packed {
    logic link_rst;
    logic [1:0] tsync;
    logic tlast;
    logic wr;
    logic [`SCP_ADDR_W-1:0] addr;
    logic [`SCP_DATA_W-1:0] data;
    logic upd;
    logic [HOLD_CNT-1:0][`SCP_DATA_W-1:0] pend;
    logic [HOLD_CNT-1:0][`SCP_DATA_W-1:0] act;
  } scp_core_state_t;

  typedef struct packed {
    scp_phase_t phase;
    logic [2:0] bitcnt;
    logic rw;
    logic [`SCP_ADDR_W-1:0] addr;
    logic [`SCP_DATA_W-1:0] shift;
  } scp_link_state_t;

  typedef struct packed {
    logic sdio;
    logic sdio_oe;
    logic serial_data_out_pin;
    logic sdo_oe;
  } scp_tx_state_t;

  scp_core_state_t cq, cd;
  scp_link_state_t lq, ld;
  scp_tx_state_t tq, td;

  wire logic link_arst;
  logic we;
  logic lsbf;
  logic bidir;
  logic [`SCP_DATA_W-1:0] byte_in;
  logic [`SCP_DATA_W-1:0] rdata;
  logic [`SCP_DATA_W-1:0] comm;
  logic [2:0] tx_idx;
  logic drive;
  logic wr_tog;
  logic [`SCP_ADDR_W-1:0] wr_addr;
  logic [`SCP_DATA_W-1:0] wr_data;
  logic ev;
  logic held_hit;

  // chip select high clears the frame without any clock edge
  assign link_arst = cs_n_i | cq.link_rst;

  assign lsbf = comm[`SCP_COMM_LSBF_BIT];
  assign bidir = comm[`SCP_COMM_BIDIR_BIT];

  scp_regfile u_regfile (
    .sclk_i(sclk_i),
    .arst_i(cq.link_rst),
    .we_i(we),
    .waddr_i(lq.addr),
    .wdata_i(byte_in),
    .raddr_i(lq.addr),
    .rdata_o(rdata),
    .comm_o(comm),
    .wr_tog_o(wr_tog),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // link receive: assemble bytes, decode instruction, step address
  always_comb begin
    ld = lq;
    we = 1'b0;
    if (lsbf) begin
      byte_in = {sdio_i, lq.shift[`SCP_DATA_W-1:1]};
    end else begin
      byte_in = {lq.shift[`SCP_DATA_W-2:0], sdio_i};
    end
    ld.shift = byte_in;
    ld.bitcnt = lq.bitcnt + `SCP_BIT_STEP;
    if (lq.bitcnt == `SCP_BIT_LAST) begin
      if (lq.phase == SCP_INSTR) begin
        ld.phase = SCP_DATA;
        ld.rw = byte_in[`SCP_RW_BIT];
        ld.addr = byte_in[`SCP_ADDR_W-1:0];
      end else begin
        we = ~lq.rw;
        // 7-bit wrap beyond the end stops nothing; host bounds the burst
        if (lsbf) begin
          ld.addr = lq.addr + `SCP_ADDR_STEP;
        end else begin
          ld.addr = lq.addr - `SCP_ADDR_STEP;
        end
      end
    end
  end

  // frame state, back to the instruction phase whenever cs is high
  always_ff @(posedge sclk_i or posedge link_arst) begin
    if (link_arst) begin
      lq.phase <= SCP_INSTR;
      lq.bitcnt <= `SCP_BIT_FIRST;
      lq.rw <= 1'b0;
      lq.addr <= '0;
      lq.shift <= '0;
    end else begin
      lq <= ld;
    end
  end

  // link transmit: pick the bit for the current position of the byte
  always_comb begin
    td = tq;
    drive = (lq.phase == SCP_DATA) && lq.rw;
    if (lsbf) begin
      tx_idx = lq.bitcnt;
    end else begin
      tx_idx = `SCP_BIT_LAST - lq.bitcnt;
    end
    td.sdio = rdata[tx_idx];
    td.serial_data_out_pin = rdata[tx_idx];
    td.sdio_oe = drive & bidir;
    td.sdo_oe = drive & ~bidir;
  end

  // falling edge gives the host a full half period of setup
  always_ff @(negedge sclk_i or posedge link_arst) begin
    if (link_arst) begin
      tq <= '0;
    end else begin
      tq <= td;
    end
  end

  // core side: catch the write toggle, stage held registers
  always_comb begin
    cd = cq;
    cd.link_rst = rst_i;
    cd.tsync = {cq.tsync[0], wr_tog};
    cd.tlast = cq.tsync[1];
    ev = cq.tsync[1] ^ cq.tlast;
    held_hit = 1'b0;
    cd.wr = 1'b0;
    cd.upd = 1'b0;
    for (int i = 0; i < HOLD_CNT; i++) begin
      if (ev && (wr_addr == HOLD_BASE + `SCP_ADDR_W'(i))) begin
        cd.pend[i] = wr_data;
        held_hit = 1'b1;
      end
    end
    if (ev && !held_hit) begin
      cd.wr = 1'b1;
      cd.addr = wr_addr;
      cd.data = wr_data;
    end
    if (ev && (wr_addr == `SCP_FUPD_ADDR) && wr_data[`SCP_FUPD_BIT]) begin
      cd.act = cq.pend;
      cd.upd = 1'b1;
    end
  end

  // word is stable long before its toggle arrives, so it needs no sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cq <= '0;
      cq.link_rst <= 1'b1;
    end else begin
      cq <= cd;
    end
  end

  assign sdio_o = tq.sdio;
  assign sdio_oe_o = tq.sdio_oe;
  assign serial_data_out_pin_o = tq.serial_data_out_pin;
  assign serial_data_out_pin_oe_o = tq.sdo_oe;
  assign reg_wr_o = cq.wr;
  assign reg_addr_o = cq.addr;
  assign reg_data_o = cq.data;
  assign freq_update_o = cq.upd;
  assign held_active_o = cq.act;

endmodule // scp_top

// *** scp_properties.sv ***
// scp_properties: port checks of scp_top on the core clock
// assumes it is bound to scp_top and sees only its ports
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_properties #(
  parameter logic [`SCP_ADDR_W-1:0] HOLD_BASE = 7'h30,
  parameter int HOLD_CNT = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sdio_oe_o,
  input wire logic serial_data_out_pin_oe_o,
  input wire logic reg_wr_o,
  input wire logic [`SCP_ADDR_W-1:0] reg_addr_o,
  input wire logic [`SCP_DATA_W-1:0] reg_data_o,
  input wire logic freq_update_o,
  input wire logic [HOLD_CNT*`SCP_DATA_W-1:0] held_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic fwr;
  // update write seen at the core side
  assign fwr = reg_wr_o && reg_addr_o == `SCP_FUPD_ADDR
    && reg_data_o[`SCP_FUPD_BIT];
  property p_float;
    cs_n_i |-> !sdio_oe_o && !serial_data_out_pin_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("pin driven");
  property p_one_pin;
    !(sdio_oe_o && serial_data_out_pin_oe_o);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("two pins");
  // byte writes sit at least nine core clock cycles apart
  property p_pulse;
    reg_wr_o |=> !reg_wr_o [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_fupd;
    freq_update_o |-> fwr;
  endproperty
  a_fupd: assert property (p_fupd) else $error("stray update");
  property p_fupd_seen;
    fwr |-> freq_update_o;
  endproperty
  a_fupd_seen: assert property (p_fupd_seen) else $error("no update");
  property p_held;
    $changed(held_active_o) |-> freq_update_o;
  endproperty
  a_held: assert property (p_held) else $error("held moved");
  property p_no_held_wr;
    reg_wr_o |-> reg_addr_o < HOLD_BASE || reg_addr_o >= HOLD_BASE + HOLD_CNT;
  endproperty
  a_no_held_wr: assert property (p_no_held_wr) else $error("held wr");
  property p_addr_hold;
    $changed(reg_addr_o) || $changed(reg_data_o) |-> reg_wr_o;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
  c_wr: cover property (reg_wr_o);
  c_fupd: cover property (freq_update_o);
  c_bidir: cover property (sdio_oe_o);
endmodule // scp_properties

bind scp_top scp_properties #(.HOLD_BASE(HOLD_BASE), .HOLD_CNT(HOLD_CNT))
  i_scp_properties (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .sdio_oe_o(sdio_oe_o),
  .serial_data_out_pin_oe_o(serial_data_out_pin_oe_o),
  .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
  .freq_update_o(freq_update_o), .held_active_o(held_active_o));

// *** scp_host.sv ***
// scp_host: serial master model, 15 ns serial clock, still outside frames
// assumes the bench resolves the data pin and feeds it back on miso_i
`timescale 1ns/1ps

module scp_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // cs stays low for the whole cycle
  task automatic start();
    cs_n_o = 1'b0;
    #20;
  endtask
  task automatic stop();
    #20 cs_n_o = 1'b1;
    #30;
  endtask
  // nb bits of one byte; on reads the line toggles so stale bits never pass
  task automatic xfer(input logic [7:0] tx, input logic lsbf, input logic rd,
    input int nb, output logic [7:0] rx);
    int b;
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      b = lsbf ? i : 7 - i;
      mosi_o = rd ? ~mosi_o : tx[b];
      #7.5 rx[b] = miso_i;
      sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
  endtask
endmodule // scp_host

// *** tb_top.sv ***
// tb_top: directed checks of scp_top through the host model
// assumes scp_host drives the link and the bench resolves the pins
`timescale 1ns/1ps
`include "scp_consts.svh"

module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, cs_n, mosi, sdio_i, sdio_o, sdio_oe_o, serial_data_out_pin, sdo_oe;
  logic reg_wr_o, freq_update_o, lsbf = 1'b0, bidir = 1'b0;
  logic [6:0] reg_addr_o;
  logic [7:0] reg_data_o;
  logic [47:0] held_active_o;
  logic [7:0] rd_q [2];
  logic [14:0] wr_q [$];
  int num_errors = 0, tests_run = 0, fupd = 0;
  always #4 clk_i = ~clk_i;
  // two-way pin resolves to whichever side drives it
  assign sdio_i = sdio_oe_o ? sdio_o : mosi;
  // a released output pin shows the inverse of its last bit, so a
  // missing enable cannot pass for good read data
  scp_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(bidir ? sdio_i : (sdo_oe ? serial_data_out_pin : ~serial_data_out_pin)));
  scp_top i_scp_top (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
    .serial_data_out_pin_o(serial_data_out_pin), .serial_data_out_pin_oe_o(sdo_oe),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
    .freq_update_o(freq_update_o), .held_active_o(held_active_o));
  // log core write pulses
  always @(posedge clk_i) begin
    if (reg_wr_o === 1'b1) wr_q.push_back({reg_addr_o, reg_data_o});
    if (freq_update_o === 1'b1) fupd++;
  end
  task automatic chk(input string name, input logic [47:0] seen,
    input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // one frame: an 8-bit instruction byte, then n data bytes of nb bits each; then room for core delivery
  task automatic frm(input logic [7:0] ins, input logic [7:0] d0,
    input logic [7:0] d1, input int n, input int nb);
    logic [7:0] t;
    wr_q.delete();
    i_host.start();
    i_host.xfer(ins, lsbf, 1'b0, 8, t);
    for (int k = 0; k < n; k++)
      i_host.xfer(k ? d1 : d0, lsbf, ins[7], nb, rd_q[k]);
    i_host.stop();
    #100;
  endtask
  task automatic t_msb();
    frm(8'h05, 8'h12, 8'h34, 2, 8);
    chk("write count", wr_q.size(), 48'h2);
    chk("first write", wr_q[0], {1'b0, 7'h05, 8'h12});
    chk("second write", wr_q[1], {1'b0, 7'h04, 8'h34});
    frm(8'h85, 8'h00, 8'h00, 2, 8);
    chk("first read", rd_q[0], 48'h12);
    chk("second read", rd_q[1], 48'h34);
  endtask
  task automatic t_lsb();
    frm(8'h00, 8'hC0, 8'h00, 1, 8);
    bidir = 1'b1;
    lsbf = 1'b1;
    frm(8'h10, 8'hA5, 8'h3C, 2, 8);
    chk("lsb first write", wr_q[0], {1'b0, 7'h10, 8'hA5});
    chk("lsb second write", wr_q[1], {1'b0, 7'h11, 8'h3C});
    frm(8'h90, 8'h00, 8'h00, 2, 8);
    chk("lsb reads", {rd_q[0], rd_q[1]}, 48'hA53C);
    frm(8'h00, 8'h00, 8'h00, 1, 8);
    bidir = 1'b0;
    lsbf = 1'b0;
  endtask
  task automatic t_abort();
    frm(8'h20, 8'hFF, 8'h00, 1, 5);
    chk("cut write count", wr_q.size(), 48'h0);
    frm(8'hA0, 8'h00, 8'h00, 1, 8);
    chk("cut byte reg", rd_q[0], 48'h0);
  endtask
  task automatic t_hold();
    frm(8'h30, 8'hAA, 8'h00, 1, 8);
    chk("held write count", wr_q.size(), 48'h0);
    chk("held before update", held_active_o, 48'h0);
    fupd = 0;
    frm(8'h36, 8'h01, 8'h00, 1, 8);
    chk("update count", fupd, 48'h1);
    chk("held after update", held_active_o, 48'hAA);
  endtask
  // mid-run reset must clear the array and the held stage
  task automatic t_reset();
    frm(8'h07, 8'h5A, 8'h00, 1, 8);
    chk("pre-reset write", wr_q[0], {1'b0, 7'h07, 8'h5A});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("held after reset", held_active_o, 48'h0);
    frm(8'h87, 8'h00, 8'h00, 1, 8);
    chk("reg after reset", rd_q[0], 48'h0);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #60000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_msb();
    t_lsb();
    t_abort();
    t_hold();
    t_reset();
    report_and_stop();
  end
endmodule // tb_top
